// >>> tslb_top.sv
// Tape serial link with Break handshake and autonomous boot streaming.
`timescale 1ns/100ps
module tslb_top import tslb_pkg::*; #(
  parameter int unsigned BOOT_DELAY = BOOT_DELAY_CYC,
  parameter int unsigned GROUP_GAP = GAP_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Rate straps; use_default selects 38400 both ways
  input wire logic use_default,
  input wire logic [3:0] tx_rate_select,
  input wire logic [3:0] rx_rate_select,
  // Serial line
  input wire logic rxd,
  output logic txd,
  // Boot switch, low when closed
  input wire logic boot_n,
  // Tape side
  input wire logic tape_at_block0,
  input wire logic [7:0] tape_data,
  input wire logic tape_valid,
  output logic tape_seek_q,
  output logic tape_take_q,
  output logic tape_motion_q,
  // Indicators and host-side user port
  output logic run_led_q,
  output logic [7:0] rx_data_q,
  output logic rx_valid_q,
  output logic linked_q
);
  tslb_tx_if tx_bus ();
  logic [3:0] tx_sel, rx_sel;

  // ****************************************
  // Rate selection
  // ****************************************
  always_comb begin
    tx_sel = use_default ? RATE_DEFAULT : tx_rate_select;
    rx_sel = use_default ? RATE_DEFAULT : rx_rate_select;
  end

  tslb_tx u_tx (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tx_rate_select(tx_sel),
    .req(tx_bus.txr),
    .txd_q(txd)
  );

  // ****************************************
  // Receiver and Break detection
  // ****************************************
  logic [19:0] rdiv_q, rdiv_d;
  logic [3:0] rbit_q, rbit_d;
  logic [7:0] rsh_q, rsh_d, rx_data_d;
  logic rbusy_q, rbusy_d, rx_valid_d;
  logic [23:0] spc_q, spc_d;
  logic brk_seen_q, brk_seen_d;
  logic [1:0] init_cnt_q, init_cnt_d;
  logic cont_req_q, cont_req_d, linked_d;
  logic [23:0] frame_cyc;
  logic boot_active;

  always_comb begin
    frame_cyc = 24'(tslb_bit_div(rx_sel)) * 24'(FRAME_BITS);
    rdiv_d = rdiv_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    rbusy_d = rbusy_q;
    rx_data_d = rx_data_q;
    rx_valid_d = 1'b0;
    spc_d = rxd ? 24'h000000 : ((spc_q > frame_cyc) ? spc_q : spc_q + 24'h000001);
    brk_seen_d = brk_seen_q;
    init_cnt_d = init_cnt_q;
    cont_req_d = cont_req_q;
    linked_d = linked_q;
    // Cleared before the frame logic so that a new request in the same cycle wins.
    if (cont_req_q && tx_bus.ready && !boot_active) begin
      cont_req_d = 1'b0;
    end
    if (spc_q > frame_cyc) begin
      brk_seen_d = 1'b1;
      init_cnt_d = 2'h0;
      rbusy_d = 1'b0;
      linked_d = 1'b0;
    end else if (!rbusy_q) begin
      if (!rxd) begin
        rbusy_d = 1'b1;
        rbit_d = 4'h0;
        rdiv_d = tslb_bit_div(rx_sel) >> 1;
      end
    end else if (rdiv_q > 20'h00001) begin
      rdiv_d = rdiv_q - 20'h00001;
    end else begin
      rdiv_d = tslb_bit_div(rx_sel);
      rbit_d = rbit_q + 4'h1;
      if (rbit_q == 4'h0 && rxd) begin
        rbusy_d = 1'b0;
      end else if (rbit_q >= 4'h1 && rbit_q <= 4'h8) begin
        rsh_d = {rxd, rsh_q[7:1]};
      end else if (rbit_q == 4'h9) begin
        rbusy_d = 1'b0;
        if (rxd) begin
          rx_data_d = rsh_q;
          rx_valid_d = 1'b1;
          if (brk_seen_q && rsh_q == CODE_INIT) begin
            init_cnt_d = init_cnt_q + 2'h1;
            if (init_cnt_q == 2'h1) begin
              cont_req_d = 1'b1;
              brk_seen_d = 1'b0;
              linked_d = 1'b1;
            end
          end else begin
            init_cnt_d = 2'h0;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdiv_q <= 20'h00000;
      rbit_q <= 4'h0;
      rsh_q <= 8'h00;
      rbusy_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      spc_q <= 24'h000000;
      brk_seen_q <= 1'b0;
      init_cnt_q <= 2'h0;
      cont_req_q <= 1'b0;
      linked_q <= 1'b0;
    end else begin
      rdiv_q <= rdiv_d;
      rbit_q <= rbit_d;
      rsh_q <= rsh_d;
      rbusy_q <= rbusy_d;
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      spc_q <= spc_d;
      brk_seen_q <= brk_seen_d;
      init_cnt_q <= init_cnt_d;
      cont_req_q <= cont_req_d;
      linked_q <= linked_d;
    end
  end

  // ****************************************
  // Boot sequencer
  // ****************************************
  tslb_boot_t st_q, st_d;
  logic [31:0] tmr_q, tmr_d;
  logic [2:0] grp_q, grp_d;
  logic sw_q, sw_d, armed_q, armed_d, first_q, first_d;
  logic seek_d, take_d, motion_d, rate_ok;

  assign boot_active = (st_q != TSLB_IDLE);

  always_comb begin
    rate_ok = (tx_sel == RATE_9600) || (tx_sel == RATE_19200) ||
              (tx_sel == RATE_38400);
    st_d = st_q;
    tmr_d = tmr_q;
    grp_d = grp_q;
    sw_d = !boot_n;
    armed_d = armed_q;
    first_d = 1'b0;
    seek_d = 1'b0;
    take_d = 1'b0;
    tx_bus.valid = 1'b0;
    tx_bus.brk = 1'b0;
    tx_bus.data = CODE_CONTINUE;
    if (!sw_q) begin
      armed_d = 1'b1;
    end
    case (st_q)
      TSLB_IDLE: begin
        tx_bus.valid = cont_req_q;
        // The power-up check reads the pin in the first cycle after reset.
        if (rate_ok && ((first_q && !boot_n) || (armed_q && sw_q))) begin
          st_d = TSLB_DELAY;
          tmr_d = 32'(BOOT_DELAY);
          armed_d = 1'b0;
        end
      end
      TSLB_DELAY: begin
        tmr_d = tmr_q - 32'h00000001;
        if (tmr_q <= 32'h00000001) begin
          st_d = TSLB_SEEK;
        end
      end
      TSLB_SEEK: begin
        seek_d = !tape_at_block0;
        if (tape_at_block0) begin
          st_d = TSLB_BRK;
        end
      end
      TSLB_BRK: begin
        tx_bus.valid = 1'b1;
        tx_bus.brk = 1'b1;
        if (tx_bus.ready) begin
          st_d = TSLB_SEND;
          grp_d = 3'h0;
        end
      end
      TSLB_SEND: begin
        tx_bus.valid = tape_valid;
        tx_bus.data = tape_data;
        if (tape_valid && tx_bus.ready) begin
          take_d = 1'b1;
          grp_d = grp_q + 3'h1;
          if (tape_data == CODE_BOOT_END) begin
            st_d = TSLB_IDLE;
          end else if (grp_q == 3'(GROUP_LEN - 1)) begin
            st_d = TSLB_GAP;
            tmr_d = 32'(GROUP_GAP);
          end
        end
      end
      TSLB_GAP: begin
        // The count holds at zero while the transmitter finishes.
        if (tmr_q != 32'h00000000) begin
          tmr_d = tmr_q - 32'h00000001;
        end
        if (tmr_q <= 32'h00000001 && tx_bus.ready) begin
          st_d = TSLB_SEND;
          grp_d = 3'h0;
        end
      end
      default: begin
        st_d = TSLB_IDLE;
      end
    endcase
    motion_d = seek_d || (st_q == TSLB_SEND) || (st_q == TSLB_GAP);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= TSLB_IDLE;
      tmr_q <= 32'h00000000;
      grp_q <= 3'h0;
      sw_q <= 1'b0;
      armed_q <= 1'b0;
      first_q <= 1'b1;
      tape_seek_q <= 1'b0;
      tape_take_q <= 1'b0;
      tape_motion_q <= 1'b0;
      run_led_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      grp_q <= grp_d;
      sw_q <= sw_d;
      armed_q <= armed_d;
      first_q <= first_d;
      tape_seek_q <= seek_d;
      tape_take_q <= take_d;
      tape_motion_q <= motion_d;
      run_led_q <= motion_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_led_follows_motion: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run_led_q == tape_motion_q) else $error("run indicator not tracking motion");
  chk_boot_end_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == TSLB_SEND && tape_valid && tx_bus.ready && tape_data == CODE_BOOT_END)
    |=> st_q == TSLB_IDLE) else $error("boot did not end on terminator");
  chk_delay_from_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == TSLB_IDLE && $changed(st_q) == 1'b0 && st_d == TSLB_DELAY)
    |=> tmr_q == 32'(BOOT_DELAY)) else $error("boot delay not loaded");
  chk_boot_rate_ok: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == TSLB_IDLE && tx_sel != RATE_9600 && tx_sel != RATE_19200 &&
    tx_sel != RATE_38400) |=> st_q == TSLB_IDLE)
    else $error("boot started at unsupported rate");
  chk_brk_after_seek: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == TSLB_SEEK && tape_at_block0) |=> st_q == TSLB_BRK)
    else $error("break not sent after seek");
  chk_group_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q == TSLB_SEND && st_d == TSLB_GAP) |-> grp_q == 3'(GROUP_LEN - 1))
    else $error("gap before seven characters");
  chk_continue_sent: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($rose(cont_req_q) && st_q == TSLB_IDLE && tx_bus.ready) |->
    (tx_bus.valid && tx_bus.data == CODE_CONTINUE) ##1 !txd)
    else $error("continue code not offered");
  chk_break_detect: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (spc_q > frame_cyc) |=> brk_seen_q) else $error("break not detected");
endmodule : tslb_top

// >>> tslb_pkg.sv
// Package of constants and types for the tape serial link and boot block.
package tslb_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned BOOT_DELAY_MS = 1000;
  localparam int unsigned BOOT_DELAY_CYC = (CLK_HZ / 1000) * BOOT_DELAY_MS;
  localparam int unsigned GAP_BAUD = 9600;
  localparam int unsigned GAP_CHARS = 15;
  localparam int unsigned FRAME_BITS = 10;
  localparam int unsigned GAP_CYC = (CLK_HZ / GAP_BAUD) * FRAME_BITS * GAP_CHARS;
  localparam int unsigned BREAK_TX_BITS = 20;
  localparam int unsigned GROUP_LEN = 7;
  // ****************************************
  // Rate selection
  // ****************************************
  localparam logic [3:0] RATE_150 = 4'h0;
  localparam logic [3:0] RATE_9600 = 4'h6;
  localparam logic [3:0] RATE_19200 = 4'h7;
  localparam logic [3:0] RATE_38400 = 4'h8;
  localparam logic [3:0] RATE_DEFAULT = RATE_38400;
  localparam int unsigned DIV_38400 = CLK_HZ / 38400;
  // ****************************************
  // Link codes
  // ****************************************
  localparam logic [7:0] CODE_INIT = 8'h04;
  localparam logic [7:0] CODE_CONTINUE = 8'h10;
  localparam logic [7:0] CODE_BOOT_END = 8'h67;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    TSLB_IDLE, TSLB_DELAY, TSLB_SEEK, TSLB_BRK, TSLB_SEND, TSLB_GAP
  } tslb_boot_t;

  // Bit period in clock cycles for a rate code, 150 baud doubled per step, held at 38400 for codes above RATE_38400.
  function automatic logic [19:0] tslb_bit_div(input logic [3:0] sel);
    int unsigned baud;
    baud = 150 << sel;
    if (sel > RATE_38400) begin
      baud = 38400;
    end
    return 20'(CLK_HZ / baud);
  endfunction : tslb_bit_div
endpackage : tslb_pkg

// >>> tslb_tx_if.sv
// Interface between the boot controller and the transmitter.
`timescale 1ns/100ps
interface tslb_tx_if;
  logic valid;
  logic brk;
  logic [7:0] data;
  logic ready;
  modport ctrl (output valid, output brk, output data, input ready);
  modport txr (input valid, input brk, input data, output ready);
endinterface : tslb_tx_if

// >>> tslb_tx.sv
// Serial transmitter: 8N1 frames and timed Break.
`timescale 1ns/100ps
module tslb_tx import tslb_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Rate
  input wire logic [3:0] tx_rate_select,
  // Request port
  tslb_tx_if.txr req,
  // Line
  output logic txd_q
);
  logic [19:0] div_q, div_d;
  logic [4:0] bit_q, bit_d;
  logic [9:0] sh_q, sh_d;
  logic busy_q, busy_d, brk_q, brk_d, txd_d;

  assign req.ready = !busy_q;

  always_comb begin
    div_d = div_q;
    bit_d = bit_q;
    sh_d = sh_q;
    busy_d = busy_q;
    brk_d = brk_q;
    txd_d = txd_q;
    if (!busy_q) begin
      txd_d = 1'b1;
      if (req.valid) begin
        busy_d = 1'b1;
        brk_d = req.brk;
        div_d = tslb_bit_div(tx_rate_select);
        sh_d = {1'b1, req.data, 1'b0};
        bit_d = req.brk ? 5'(BREAK_TX_BITS) : 5'(FRAME_BITS);
        txd_d = 1'b0;
      end
    end else if (div_q > 20'h00001) begin
      div_d = div_q - 20'h00001;
    end else begin
      div_d = tslb_bit_div(tx_rate_select);
      bit_d = bit_q - 5'h01;
      sh_d = {1'b1, sh_q[9:1]};
      if (bit_q == 5'h01) begin
        busy_d = 1'b0;
        txd_d = 1'b1;
      end else begin
        txd_d = brk_q ? 1'b0 : sh_q[1];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 20'h00000;
      bit_q <= 5'h00;
      sh_q <= 10'h3FF;
      busy_q <= 1'b0;
      brk_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      div_q <= div_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      busy_q <= busy_d;
      brk_q <= brk_d;
      txd_q <= txd_d;
    end
  end

  chk_tx_start_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (req.valid && req.ready) |=> !txd_q) else $error("tx start bit missing");
endmodule : tslb_tx

// >>> tslb_host_model.sv
// Behavioural host serial line that talks to the tape serial link.
`timescale 1ns/100ps
module tslb_host_model import tslb_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Serial line, seen from the host
  output logic rxd,
  input wire logic txd
);
  int unsigned tx_cyc;
  int unsigned rx_cyc;
  int unsigned brk_count;
  logic [7:0] got_q[$];

  initial begin
    rxd = 1'b1;
    tx_cyc = CLK_HZ / 38400;
    rx_cyc = CLK_HZ / 38400;
    brk_count = 0;
  end

  // Holds the line at one level for a whole number of bit times.
  task automatic line_level(input logic b, input int unsigned bits);
    @(posedge sys_clk);
    #1 rxd = b;
    repeat (bits * tx_cyc - 1) @(posedge sys_clk);
  endtask : line_level

  task automatic send_byte(input logic [7:0] b);
    line_level(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      line_level(b[i], 1);
    end
    line_level(1'b1, 1);
  endtask : send_byte

  task automatic synchronise;
    line_level(1'b0, 12);
    line_level(1'b1, 1);
    send_byte(8'h04);
    send_byte(8'h04);
  endtask : synchronise

  // A frame whose stop position is space is taken as Break from the device.
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge txd);
      repeat (rx_cyc / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (rx_cyc) @(posedge sys_clk);
        b[i] = txd;
      end
      repeat (rx_cyc) @(posedge sys_clk);
      if (txd === 1'b1) begin
        got_q.push_back(b);
      end else begin
        brk_count++;
        wait (txd === 1'b1);
      end
    end
  end
endmodule : tslb_host_model

// >>> tape_serial_link_boot_tb_top.sv
// Self-checking testbench for the tape serial link and boot block.
`timescale 1ns/100ps
module tape_serial_link_boot_tb_top import tslb_pkg::*;;
  localparam int unsigned DELAY_TB = 50;
  localparam int unsigned GAP_TB = 40000;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic use_default = 1'b1;
  logic [3:0] tx_rate_select = 4'h0;
  logic [3:0] rx_rate_select = 4'h0;
  logic rxd, txd, boot_n = 1'b1, tape_at_block0 = 1'b0, feed_on = 1'b0;
  logic tape_seek_q, tape_take_q, tape_motion_q, run_led_q, rx_valid_q, linked_q;
  logic [7:0] rx_data_q, tape_data;
  logic tape_valid;
  logic [7:0] boot_chars [8] = '{8'h4C, 8'h4F, 8'h41, 8'h44, 8'h45, 8'h52, 8'h53, 8'h67};
  int unsigned err_count = 0, samples_checked = 0, cyc = 0, tidx = 0, rx_pulses = 0;
  int unsigned take_t[$];

  tslb_top #(.BOOT_DELAY(DELAY_TB), .GROUP_GAP(GAP_TB)) tslb_top_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .use_default(use_default),
    .tx_rate_select(tx_rate_select), .rx_rate_select(rx_rate_select),
    .rxd(rxd), .txd(txd), .boot_n(boot_n), .tape_at_block0(tape_at_block0),
    .tape_data(tape_data), .tape_valid(tape_valid), .tape_seek_q(tape_seek_q),
    .tape_take_q(tape_take_q), .tape_motion_q(tape_motion_q), .run_led_q(run_led_q),
    .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .linked_q(linked_q));
  tslb_host_model tslb_host_model_inst (.sys_clk(sys_clk), .rxd(rxd), .txd(txd));

  always #5 sys_clk = ~sys_clk;
  assign tape_data = (tidx < 8) ? boot_chars[tidx] : 8'h00;
  assign tape_valid = feed_on && (tidx < 8);

  // Outputs are sampled on the falling edge, clear of the launching edge.
  always @(negedge sys_clk) begin
    cyc++;
    if (rx_valid_q === 1'b1) rx_pulses++;
    if (tape_take_q === 1'b1) begin
      take_t.push_back(cyc);
      tidx++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic wait_got(input int unsigned n, input int unsigned limit);
    for (int unsigned i = 0; i < limit && tslb_host_model_inst.got_q.size() < n; i++) begin
      @(posedge sys_clk);
    end
  endtask : wait_got

  task automatic t_reset;
    check(txd, 1'b1, "idle line");
    check(linked_q, 1'b0, "linked at reset");
    check(run_led_q, 1'b0, "indicator at reset");
  endtask : t_reset

  // Selects are at 150 but the default strap forces 38400 both ways.
  task automatic t_handshake;
    tslb_host_model_inst.synchronise();
    repeat (10) @(posedge sys_clk);
    check(rx_data_q, 8'h04, "last byte");
    check(linked_q, 1'b1, "linked");
    wait_got(1, 40000);
    check(tslb_host_model_inst.got_q.size(), 1, "answer count");
    check(tslb_host_model_inst.got_q[0], 8'h10, "continue code");
  endtask : t_handshake

  task automatic t_rates;
    int unsigned p;
    @(posedge sys_clk);
    #1 use_default = 1'b0;
    tx_rate_select = 4'h8;
    rx_rate_select = 4'h7;
    tslb_host_model_inst.tx_cyc = CLK_HZ / 19200;
    p = rx_pulses;
    tslb_host_model_inst.send_byte(8'hA5);
    repeat (10) @(posedge sys_clk);
    check(rx_data_q, 8'hA5, "byte at own rate");
    check(rx_pulses, p + 1, "receive pulses");
  endtask : t_rates

  task automatic t_boot_refused;
    @(posedge sys_clk);
    #1 tx_rate_select = 4'h0;
    boot_n = 1'b0;
    repeat (200) @(posedge sys_clk);
    check(tape_seek_q, 1'b0, "boot at slow rate");
    #1 boot_n = 1'b1;
    tx_rate_select = 4'h8;
    repeat (10) @(posedge sys_clk);
  endtask : t_boot_refused

  task automatic t_boot;
    int unsigned b;
    b = tslb_host_model_inst.brk_count;
    @(posedge sys_clk);
    #1 boot_n = 1'b0;
    repeat (DELAY_TB - 20) @(posedge sys_clk);
    check(tape_seek_q, 1'b0, "seek before delay");
    repeat (60) @(posedge sys_clk);
    check(tape_seek_q, 1'b1, "seek after delay");
    check(run_led_q, 1'b1, "indicator lit");
    repeat (100) @(posedge sys_clk);
    check(tslb_host_model_inst.brk_count, b, "no Break before position");
    #1 tape_at_block0 = 1'b1;
    feed_on = 1'b1;
    for (int unsigned i = 0; i < 80000 && tslb_host_model_inst.brk_count == b; i++) begin
      @(posedge sys_clk);
    end
    check(tslb_host_model_inst.brk_count, b + 1, "Break sent");
    check(tslb_host_model_inst.got_q.size(), 1, "no char before Break");
    wait_got(9, 320000);
    for (int i = 0; i < 8; i++) begin
      check(tslb_host_model_inst.got_q[i + 1], boot_chars[i], "boot char");
    end
    check(take_t.size(), 8, "characters taken");
    check(take_t[6] - take_t[5] < GAP_TB, 1'b1, "no gap inside group");
    check(take_t[7] - take_t[6] >= GAP_TB, 1'b1, "gap after seven");
    repeat (20) @(posedge sys_clk);
    check(tape_motion_q, 1'b0, "idle after end char");
    check(run_led_q, 1'b0, "indicator off");
  endtask : t_boot

  // A reset in mid-run with the boot switch closed stands for a power-up boot.
  task automatic t_powerup_boot;
    @(posedge sys_clk);
    #1 rst_n = 1'b0;
    boot_n = 1'b0;
    tape_at_block0 = 1'b0;
    feed_on = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    repeat (DELAY_TB - 20) @(posedge sys_clk);
    check(tape_seek_q, 1'b0, "seek before power-up delay");
    repeat (40) @(posedge sys_clk);
    check(tape_seek_q, 1'b1, "power-up boot seek");
    check(run_led_q, 1'b1, "indicator at power-up seek");
  endtask : t_powerup_boot

  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_handshake();
    t_rates();
    t_boot_refused();
    t_boot();
    t_powerup_boot();
    finish_test();
  end

  initial begin
    repeat (900000) @(posedge sys_clk);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : tape_serial_link_boot_tb_top
